//--- shared/pump_regs_pkg.sv
/*
 Package for the pump-station holding-register bank: register offsets,
 value codes, exception codes and the request/answer carriers.
 Assumes one 16-bit holding register per protocol address.
*/
package pump_regs_pkg;

   // ==========================================================
   // Register offsets (protocol addresses)
   // ==========================================================
   localparam logic [15:0] OFS_VERSION = 16'h0000;
   localparam logic [15:0] OFS_BLINK   = 16'h0001;
   localparam logic [15:0] OFS_VARIANT = 16'h0002;
   localparam logic [15:0] OFS_TIMER   = 16'h000D;
   localparam logic [15:0] OFS_DRIVES  = 16'h000E;
   localparam logic [15:0] OFS_REGMODE = 16'h0018;
   localparam logic [15:0] OFS_MEAS    = 16'h0019;
   localparam logic [15:0] OFS_PUMP1   = 16'h0028;
   localparam logic [15:0] OFS_PUMP2   = 16'h0029;
   localparam logic [15:0] OFS_PUMP3   = 16'h002A;
   localparam logic [15:0] OFS_BOX     = 16'h003D;

   // ==========================================================
   // Field positions, code limits and reset values
   // ==========================================================
   localparam int          BOX_RUN_BIT   = 0;
   localparam int          BOX_FAULT_BIT = 1;
   localparam logic [15:0] TIMER_LAST    = 16'h0005;
   localparam logic [15:0] PUMP_LAST     = 16'h0002;
   localparam logic [3:0]  MODE_LAST     = 4'hE;
   localparam logic [3:0]  MODE_FILL     = 4'hA;
   localparam logic [3:0]  MODE_EMPTY    = 4'hB;
   localparam logic [15:0] VERSION_DEF   = 16'h0001;
   localparam logic [15:0] VARIANT_DEF   = 16'h0000;

   // ==========================================================
   // Exception codes of the answer
   // ==========================================================
   localparam logic [7:0] EXC_FUNC  = 8'h01;
   localparam logic [7:0] EXC_ADDR  = 8'h02;
   localparam logic [7:0] EXC_VALUE = 8'h03;

   typedef enum logic [2:0] {
      TMR_NONE = 3'h0, TMR_OFF = 3'h1, TMR_SET = 3'h2,
      TMR_ACTIVE = 3'h3, TMR_RESET = 3'h4, TMR_MANUAL = 3'h5
   } timer_cmd_t;

   typedef enum logic [1:0] {
      PUMP_OFF = 2'h0, PUMP_HAND = 2'h1, PUMP_AUTO = 2'h2
   } pump_mode_t;

   // A 32-bit bitmap uses the same power-of-two weight per index.
   typedef logic [31:0] wide_flag_word_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] addr;
      logic [15:0] data;
   } reg_req_t;

   typedef struct packed {
      logic        valid;
      logic        exception;
      logic [7:0]  code;
      logic [15:0] data;
   } reg_rsp_t;

endpackage : pump_regs_pkg

//--- core/pump_station_modbus_regs.sv
/*
 Holding-register bank of the pump-station controller as seen by the
 remote bus master. Assumes a protocol front end that hands over one
 decoded register request per cycle and takes the answer one cycle later.
*/
// How it works
// - Signed registers carry two's-complement values from -32768 to 32767.
// - Unsigned registers carry 0 to 65535, a parameter may use less.
// - Enumerated registers only ever hold a code from their list.
// - Boolean registers read 0 or 1, and any nonzero write means true.
// - A 16-bit bitmap weights flag i by two to the power i.
// - A 32-bit bitmap uses the same weighting over thirty-two flags.
// - The command timer uses codes 0 none to 5 manual and is read-write.
// - Each pump mode is read-write with 0 off, 1 hand, 2 auto.
// - Control mode is read-only, codes 0 to 14, 10 fill, 11 drain.
// - The current value is a read-only signed measurement.
// - Read-only registers are only read, read-write ones read and written.
module pump_station_modbus_regs
   import pump_regs_pkg::*;
#(
   parameter logic [15:0] PROFILE_VERSION = pump_regs_pkg::VERSION_DEF,
   parameter logic [15:0] ENCLOSURE_VAR   = pump_regs_pkg::VARIANT_DEF
) (
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   input  wire pump_regs_pkg::reg_req_t req,
   output pump_regs_pkg::reg_rsp_t      rsp,
   input  wire logic                    collective_run_flag,
   input  wire logic                    collective_fault_flag,
   input  wire logic [3:0]              regulation_mode_in,
   input  wire logic [15:0]             measured_value_in,
   output logic                         identify_blink,
   output logic                         drives_on,
   output pump_regs_pkg::timer_cmd_t    timer_cmd,
   output pump_regs_pkg::pump_mode_t    pump_mode [3]
);
   import pump_regs_pkg::*;

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      reg_rsp_t               rsp;
      logic                   blink;
      logic                   drives;
      timer_cmd_t             timer;
      pump_mode_t [2:0]       pump;
      logic [3:0]             regmode;
      logic signed [15:0]     meas;
      logic [1:0]             box;
   } state_t;

   state_t st_reg;
   state_t st_next;

   // Exception answer helper, used by every rejected access.
   function automatic reg_rsp_t reject(input logic [7:0] code);
      reg_rsp_t r;
      r = '0;
      r.valid = 1'b1;
      r.exception = 1'b1;
      r.code = code;
      return r;
   endfunction : reject

   // Index of the pump register at an address, 3 when none.
   function automatic logic [1:0] pump_idx(input logic [15:0] addr);
      logic [1:0] i;
      i = 2'h3;
      if (addr == OFS_PUMP1) i = 2'h0;
      if (addr == OFS_PUMP2) i = 2'h1;
      if (addr == OFS_PUMP3) i = 2'h2;
      return i;
   endfunction : pump_idx

   // Weight each flag by two to the power of its index. The same weighting
   // serves both bitmap widths, so a 16-bit map is just the low half.
   function automatic wide_flag_word_t pack_flags(input logic [31:0] flags);
      wide_flag_word_t w;
      w = '0;
      for (int k = 0; k < 32; k++) begin
         if (flags[k]) begin
            w = w + (32'h00000001 << k);
         end
      end
      return w;
   endfunction : pack_flags

   // ==========================================================
   // Next state
   // ==========================================================
   // Status registers are sampled every cycle so a read shows the value
   // one cycle old; the answer never mixes a live input into the bus.
   always_comb begin
      logic [1:0]      pi;
      wide_flag_word_t bw;
      pi = pump_idx(req.addr);
      bw = pack_flags({30'h00000000, st_reg.box});
      st_next = st_reg;
      st_next.rsp = '0;
      st_next.meas = measured_value_in;
      st_next.box[BOX_RUN_BIT] = collective_run_flag;
      st_next.box[BOX_FAULT_BIT] = collective_fault_flag;
      // An out-of-list mode code is ignored and the last valid one held.
      if (regulation_mode_in <= MODE_LAST) begin
         st_next.regmode = regulation_mode_in;
      end
      if (req.valid && !req.write) begin
         st_next.rsp.valid = 1'b1;
         case (req.addr)
            OFS_VERSION: st_next.rsp.data = PROFILE_VERSION;
            OFS_BLINK:   st_next.rsp.data = {15'h0000, st_reg.blink};
            OFS_VARIANT: st_next.rsp.data = ENCLOSURE_VAR;
            OFS_TIMER:   st_next.rsp.data = {13'h0000, st_reg.timer};
            OFS_DRIVES:  st_next.rsp.data = {15'h0000, st_reg.drives};
            OFS_REGMODE: st_next.rsp.data = {12'h000, st_reg.regmode};
            OFS_MEAS:    st_next.rsp.data = st_reg.meas;
            OFS_BOX:     st_next.rsp.data = bw[15:0];
            OFS_PUMP1, OFS_PUMP2, OFS_PUMP3: begin
               st_next.rsp.data = {14'h0000, st_reg.pump[pi]};
            end
            default:     st_next.rsp = reject(EXC_ADDR);
         endcase
      end else if (req.valid) begin
         st_next.rsp.valid = 1'b1;
         st_next.rsp.data = req.data;
         case (req.addr)
            // Any nonzero value is stored as true.
            OFS_BLINK:  st_next.blink = (req.data != 16'h0000);
            OFS_DRIVES: st_next.drives = (req.data != 16'h0000);
            OFS_TIMER: begin
               if (req.data <= TIMER_LAST) begin
                  st_next.timer = timer_cmd_t'(req.data[2:0]);
               end else begin
                  st_next.rsp = reject(EXC_VALUE);
               end
            end
            OFS_PUMP1, OFS_PUMP2, OFS_PUMP3: begin
               if (req.data <= PUMP_LAST) begin
                  st_next.pump[pi] = pump_mode_t'(req.data[1:0]);
               end else begin
                  st_next.rsp = reject(EXC_VALUE);
               end
            end
            // Read-only registers keep their value; the master learns why.
            OFS_VERSION, OFS_VARIANT, OFS_REGMODE, OFS_MEAS, OFS_BOX: begin
               st_next.rsp = reject(EXC_FUNC);
            end
            default: st_next.rsp = reject(EXC_ADDR);
         endcase
      end
   end

   // ==========================================================
   // Registers
   // ==========================================================
   // Reset puts every code at its first list entry, which is off or none.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from the state flip-flops.
   assign rsp = st_reg.rsp;
   assign identify_blink = st_reg.blink;
   assign drives_on = st_reg.drives;
   assign timer_cmd = st_reg.timer;
   assign pump_mode[0] = st_reg.pump[0];
   assign pump_mode[1] = st_reg.pump[1];
   assign pump_mode[2] = st_reg.pump[2];

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // Every request answers exactly one cycle later, never otherwise.
   a_answer_one_cycle: assert property (req.valid |=> rsp.valid) else
      $error("request not answered next cycle");
   a_no_spurious_ans: assert property (!req.valid |=> !rsp.valid) else
      $error("answer without request");

   a_timer_code_range: assert property (timer_cmd <= TIMER_LAST[2:0])
      else $error("timer code outside list");
   a_pump_code_range: assert property (pump_mode[0] <= PUMP_LAST[1:0]
      && pump_mode[1] <= PUMP_LAST[1:0] && pump_mode[2] <= PUMP_LAST[1:0])
      else $error("pump mode outside list");
   a_mode_code_range: assert property (st_reg.regmode <= MODE_LAST)
      else $error("control mode outside list");

   a_bool_nonzero_true: assert property (
      req.valid && req.write && req.addr == OFS_BLINK && req.data != 16'h0000
      |=> identify_blink && rsp.data == $past(req.data) && !rsp.exception)
      else $error("nonzero write not taken as true");

   a_enum_bad_reject: assert property (
      req.valid && req.write && req.addr == OFS_TIMER && req.data > TIMER_LAST
      |=> rsp.exception && rsp.code == EXC_VALUE && $stable(timer_cmd))
      else $error("bad timer code not rejected");

   a_ro_write_reject: assert property (
      req.valid && req.write && req.addr == OFS_REGMODE
      |=> rsp.exception && rsp.code == EXC_FUNC)
      else $error("write to read-only register accepted");

   a_box_follows_flags: assert property (
      req.valid && !req.write && req.addr == OFS_BOX
      |=> rsp.data == {14'h0000, $past(collective_fault_flag, 2),
                       $past(collective_run_flag, 2)})
      else $error("box state not following flags");

   a_meas_read_value: assert property (
      req.valid && !req.write && req.addr == OFS_MEAS
      |=> rsp.data == $past(measured_value_in, 2) && !rsp.exception)
      else $error("measured value read wrong");

   // ==========================================================
   // Checks on read-only registers
   // ==========================================================
   // Every read-only address must refuse a write with the same code and
   // return no data, so the master never mistakes a refusal for an echo.
   a_ro_version_keep: assert property (
      req.valid && req.write && req.addr == OFS_VERSION
      |=> rsp.exception && rsp.code == EXC_FUNC && rsp.data == 16'h0000)
      else $error("write to version register accepted");

   a_ro_variant_keep: assert property (
      req.valid && req.write && req.addr == OFS_VARIANT
      |=> rsp.exception && rsp.code == EXC_FUNC && rsp.data == 16'h0000)
      else $error("write to variant register accepted");

   a_ro_meas_keep: assert property (
      req.valid && req.write && req.addr == OFS_MEAS
      |=> rsp.exception && rsp.code == EXC_FUNC && rsp.data == 16'h0000)
      else $error("write to measured value accepted");

   a_ro_box_keep: assert property (
      req.valid && req.write && req.addr == OFS_BOX
      |=> rsp.exception && rsp.code == EXC_FUNC && rsp.data == 16'h0000)
      else $error("write to box state accepted");

   // ==========================================================
   // Checks on read-write registers
   // ==========================================================
   // A legal pump code lands in the matching output on the answer edge.
   a_pump1_write_take: assert property (
      req.valid && req.write && req.addr == OFS_PUMP1 && req.data <= PUMP_LAST
      |=> pump_mode[0] == pump_mode_t'($past(req.data[1:0])) && !rsp.exception)
      else $error("pump 1 mode not taken");

   a_pump2_write_take: assert property (
      req.valid && req.write && req.addr == OFS_PUMP2 && req.data <= PUMP_LAST
      |=> pump_mode[1] == pump_mode_t'($past(req.data[1:0])) && !rsp.exception)
      else $error("pump 2 mode not taken");

   a_pump3_write_take: assert property (
      req.valid && req.write && req.addr == OFS_PUMP3 && req.data <= PUMP_LAST
      |=> pump_mode[2] == pump_mode_t'($past(req.data[1:0])) && !rsp.exception)
      else $error("pump 3 mode not taken");

   // An illegal pump code must leave the running mode alone.
   a_pump_bad_reject: assert property (
      req.valid && req.write && req.addr == OFS_PUMP2 && req.data > PUMP_LAST
      |=> rsp.exception && rsp.code == EXC_VALUE && $stable(pump_mode[1]))
      else $error("bad pump code not rejected");

   a_timer_write_take: assert property (
      req.valid && req.write && req.addr == OFS_TIMER && req.data <= TIMER_LAST
      |=> timer_cmd == timer_cmd_t'($past(req.data[2:0])) && !rsp.exception)
      else $error("timer code not taken");

   a_drives_bool_write: assert property (
      req.valid && req.write && req.addr == OFS_DRIVES
      |=> drives_on == ($past(req.data) != 16'h0000) && !rsp.exception)
      else $error("drives write not taken as boolean");

   // A Boolean only ever reads back as zero or one.
   a_bool_read_01: assert property (
      req.valid && !req.write && req.addr == OFS_BLINK
      |=> rsp.data[15:1] == 15'h0000 && !rsp.exception)
      else $error("boolean read beyond one");

   // Control outputs only move on an accepted write.
   a_control_held: assert property (
      !(req.valid && req.write)
      |=> $stable(timer_cmd) && $stable(drives_on) && $stable(identify_blink))
      else $error("control output moved without write");

   // Addresses above the last mapped one are refused outright.
   a_unmapped_reject: assert property (
      req.valid && req.addr > OFS_BOX
      |=> rsp.exception && rsp.code == EXC_ADDR)
      else $error("unmapped address not refused");

   // An exception carries no data, so stale words never leak out.
   a_exc_data_zero: assert property (rsp.exception |-> rsp.valid && rsp.data == 16'h0000)
      else $error("exception answer carries data");

   // ==========================================================
   // Coverage of the main scenarios
   // ==========================================================
   c_pump_auto: cover property (req.valid && req.write && req.addr == OFS_PUMP2
      && req.data == 16'h0002 ##1 pump_mode[1] == PUMP_AUTO);
   c_ro_reject: cover property (rsp.exception && rsp.code == EXC_FUNC);
   c_unmapped: cover property (rsp.exception && rsp.code == EXC_ADDR);
   c_fill_mode: cover property (st_reg.regmode == MODE_FILL);
   c_bad_value: cover property (rsp.exception && rsp.code == EXC_VALUE);

endmodule : pump_station_modbus_regs

//--- sim/pump_master_model.sv
/*
 Remote bus master model: issues one register request at a time.
 Assumes the answer comes within a few cycles of the taking edge.
*/
module pump_master_model
   import pump_regs_pkg::*;
(
   input  wire logic                    sys_clk,
   output pump_regs_pkg::reg_req_t      req,
   input  wire pump_regs_pkg::reg_rsp_t rsp
);
   timeunit 1ns;
   timeprecision 1ps;
   // =========================================================
   // Request driver
   // =========================================================
   // Idle bus shows inverted fields, so a stale value is never taken.
   initial req = '{1'b0, 1'b0, 16'hFFFF, 16'hFFFF};
   // One request pulse, then a bounded wait for the answer.
   task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                       output reg_rsp_t r);
      int n;
      n = 0;
      @(posedge sys_clk);
      req <= '{1'b1, w, a, d};
      @(posedge sys_clk);
      req <= '{1'b0, ~w, ~a, ~d};
      #1;
      while (rsp.valid !== 1'b1 && n < 4) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      r = rsp;
   endtask : xfer
   // Bitmap decode from the top bit down by subtraction.
   function automatic logic [15:0] decode16(input logic [15:0] v);
      logic [16:0] rem;
      logic [15:0] f;
      rem = {1'b0, v};
      f = 16'h0000;
      for (int i = 15; i >= 0 && rem != 0; i--) begin
         if (rem >= (17'h00001 << i)) begin
            f[i] = 1'b1;
            rem = rem - (17'h00001 << i);
         end
      end
      return f;
   endfunction : decode16
endmodule : pump_master_model

//--- sim/pump_station_modbus_regs_tb.sv
/*
 Self-checking bench for the holding-register bank.
 Assumes the master model above and the package constants.
*/
module pump_station_modbus_regs_tb;
   import pump_regs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic w; logic [15:0] a; logic [15:0] d; logic x; logic [7:0] c; logic [15:0] q;
   } row_t;
   localparam row_t ROWS [14] = '{
      '{1, 16'h000D, 16'h0005, 0, 8'h00, 16'h0005}, '{0, 16'h000D, 16'h0000, 0, 8'h00, 16'h0005},
      '{1, 16'h000D, 16'h0006, 1, 8'h03, 16'h0000}, '{1, 16'h0001, 16'h0007, 0, 8'h00, 16'h0007},
      '{0, 16'h0001, 16'h0000, 0, 8'h00, 16'h0001}, '{1, 16'h002A, 16'h0002, 0, 8'h00, 16'h0002},
      '{1, 16'h0029, 16'h0003, 1, 8'h03, 16'h0000}, '{1, 16'h0028, 16'h0001, 0, 8'h00, 16'h0001},
      '{0, 16'h0000, 16'h0000, 0, 8'h00, VERSION_DEF}, '{1, 16'h0000, 16'h0009, 1, 8'h01, 16'h0000},
      '{1, 16'h0018, 16'h0009, 1, 8'h01, 16'h0000}, '{0, 16'h0003, 16'h0000, 1, 8'h02, 16'h0000},
      '{1, 16'h000E, 16'h0000, 0, 8'h00, 16'h0000}, '{0, 16'h000E, 16'h0000, 0, 8'h00, 16'h0000}};
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        collective_run_flag = 1'b0;
   logic        collective_fault_flag = 1'b0;
   logic [3:0]  regulation_mode_in = 4'h0;
   logic [15:0] measured_value_in = 16'h0000;
   logic        identify_blink;
   logic        drives_on;
   reg_req_t    req;
   reg_rsp_t    rsp;
   reg_rsp_t    r;
   timer_cmd_t  timer_cmd;
   pump_mode_t  pump_mode [3];
   int          n_mismatch = 0;
   int          checks_done = 0;
   pump_master_model m (.sys_clk(sys_clk), .req(req), .rsp(rsp));
   pump_station_modbus_regs dut (.sys_clk(sys_clk), .rst(rst), .req(req), .rsp(rsp),
      .collective_run_flag(collective_run_flag), .collective_fault_flag(collective_fault_flag),
      .regulation_mode_in(regulation_mode_in), .measured_value_in(measured_value_in),
      .identify_blink(identify_blink), .drives_on(drives_on), .timer_cmd(timer_cmd),
      .pump_mode(pump_mode));
   // =========================================================
   // Clock, checks and closing
   // =========================================================
   initial forever #12.5 sys_clk = ~sys_clk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : complete_run
   // Status inputs pass a register stage, so give them time to land.
   task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
      repeat (3) @(posedge sys_clk);
      m.xfer(1'b0, a, 16'h0000, r);
      check({r.valid, r.exception, r.data}, {2'b10, exp});
   endtask : rd_chk
   // The watchdog allows ample margin over the fewer than a hundred cycles used.
   initial begin
      #(25 * 5000);
      n_mismatch++;
      complete_run();
   end
   // =========================================================
   // Main sequence
   // =========================================================
   initial begin
      repeat (4) @(posedge sys_clk);
      #1;
      check({rsp.valid, identify_blink, drives_on, timer_cmd}, 32'h0);
      @(posedge sys_clk);
      rst <= 1'b0;
      foreach (ROWS[i]) begin
         m.xfer(ROWS[i].w, ROWS[i].a, ROWS[i].d, r);
         check({r.valid, r.exception, r.code, r.data}, {1'b1, ROWS[i].x, ROWS[i].c, ROWS[i].q});
      end
      check({identify_blink, drives_on, timer_cmd, pump_mode[0], pump_mode[1], pump_mode[2]},
            {1'b1, 1'b0, TMR_MANUAL, PUMP_HAND, PUMP_OFF, PUMP_AUTO});
      for (int t = 0; t < 6; t++) begin
         m.xfer(1'b1, OFS_TIMER, 16'(t), r);
         check(32'(timer_cmd), 32'(t));
      end
      @(posedge sys_clk);
      collective_run_flag <= 1'b1;
      rd_chk(OFS_BOX, 16'h0001);
      @(posedge sys_clk);
      collective_run_flag <= 1'b0;
      collective_fault_flag <= 1'b1;
      rd_chk(OFS_BOX, 16'h0002);
      check(m.decode16(r.data), 16'h0002);
      @(posedge sys_clk);
      measured_value_in <= 16'h8000;
      rd_chk(OFS_MEAS, 16'h8000);
      @(posedge sys_clk);
      regulation_mode_in <= MODE_EMPTY;
      rd_chk(OFS_REGMODE, {12'h000, MODE_EMPTY});
      @(posedge sys_clk);
      regulation_mode_in <= 4'hF;
      rd_chk(OFS_REGMODE, {12'h000, MODE_EMPTY});
      complete_run();
   end
endmodule : pump_station_modbus_regs_tb
